// ### pkg/fdp_pkg.sv
package fdp_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0]  FLASH_CTRL_OFF = 8'h0E;
    localparam logic [7:0]  FLASH_DATA_OFF = 8'h0F;

    // Reset values
    localparam logic [15:0] FLASH_DATA_RST = 16'h0000;
    localparam logic [2:0]  FLASH_CMD_RST  = 3'h0;

    // Control register layout
    localparam int          CMD_LSB        = 0;
    localparam int          CMD_MSB        = 2;
    localparam int          BUSY_BIT       = 7;
    localparam logic [3:0]  CTRL_RSVD      = 4'h0;
    localparam logic [7:0]  RD_PAD         = 8'h00;

    // Flash command field codes
    localparam logic [2:0]  CMD_WR_INFO    = 3'h2;
    localparam logic [2:0]  CMD_WR_MAIN    = 3'h3;
    localparam logic [2:0]  CMD_ER_INFO    = 3'h4;
    localparam logic [2:0]  CMD_ER_PAGE    = 3'h5;
    localparam logic [2:0]  CMD_ER_MASS    = 3'h6;

    typedef enum logic [1:0] {
        FDP_IDLE = 2'b00,
        FDP_ADDR = 2'b01,
        FDP_DATA = 2'b10
    } fdp_phase_e;

    typedef enum logic {
        FDP_SEQ_IDLE = 1'b0,
        FDP_SEQ_RUN  = 1'b1
    } fdp_seq_e;

endpackage : fdp_pkg

// ### pkg/fdp_if.sv
`timescale 1ns/10ps
`default_nettype none

interface fdp_if;
    logic        start;
    logic [2:0]  cmd;
    logic [15:0] addr;
    logic [15:0] data;
    logic        busy_n;

    modport regs (output start, output cmd, output addr, output data, input busy_n);
    modport seq  (input start, input cmd, input addr, input data, output busy_n);
endinterface : fdp_if

`default_nettype wire

// ### design/fdp_seq.sv
`timescale 1ns/10ps
`default_nettype none

module fdp_seq (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register side
    fdp_if.seq               link,
    // Flash array side
    output logic             array_go,
    output logic [2:0]       array_op,
    output logic [15:0]      array_addr,
    output logic [15:0]      array_wdata,
    input  wire logic        array_done
);

    typedef struct packed {
        fdp_pkg::fdp_seq_e state;
        logic              go;
        logic [2:0]        op;
        logic [15:0]       addr;
        logic [15:0]       wdata;
    } fdp_seq_s;

    fdp_seq_s st;
    fdp_seq_s next_st;

    always_comb begin
        next_st    = st;
        next_st.go = 1'b0;
        case (st.state)
            fdp_pkg::FDP_SEQ_IDLE: begin
                if (link.start) begin
                    next_st.state = fdp_pkg::FDP_SEQ_RUN;
                    next_st.go    = 1'b1;
                    next_st.op    = link.cmd;
                    next_st.addr  = link.addr;
                    next_st.wdata = link.data;
                end
            end
            fdp_pkg::FDP_SEQ_RUN: begin
                if (array_done) begin
                    next_st.state = fdp_pkg::FDP_SEQ_IDLE;
                end
            end
            default: begin
                next_st.state = fdp_pkg::FDP_SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.busy_n = (st.state == fdp_pkg::FDP_SEQ_IDLE);
    assign array_go    = st.go;
    assign array_op    = st.op;
    assign array_addr  = st.addr;
    assign array_wdata = st.wdata;

    a_busy_on_start: assert property (@(posedge clock) disable iff (rst)
        link.start && link.busy_n |=> !link.busy_n && array_go)
        else $error("busy flag did not fall after start");

    a_busy_held_run: assert property (@(posedge clock) disable iff (rst)
        !link.busy_n && !array_done |=> !link.busy_n && !array_go)
        else $error("busy flag released before array done");

    a_busy_release: assert property (@(posedge clock) disable iff (rst)
        !link.busy_n && array_done |=> link.busy_n)
        else $error("busy flag not released after array done");

endmodule : fdp_seq

`default_nettype wire

// ### design/fdp_flash_data_port.sv
// Summary of operation
// - Data register clears to zero on reset
// - Data reads free; writes only ROM/data memory
// - Control writes ignored while busy flag low
// - Data writes inert without valid loaded command
// - Data register carries erase/program transfer values
// - Busy low from sequence end to operation end
// - Reserved command codes start no operation
`timescale 1ns/10ps
`default_nettype none

module fdp_flash_data_port (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // Write source qualifiers
    input  wire logic        FROM_ROM,
    input  wire logic        FROM_DATA_MEM,
    // Flash array
    output logic             ARRAY_GO,
    output logic      [2:0]  ARRAY_OP,
    output logic      [15:0] ARRAY_ADDR,
    output logic      [15:0] ARRAY_WDATA,
    input  wire logic        ARRAY_DONE,
    // Status
    output logic             FLASH_BUSY_N
);

    typedef struct packed {
        fdp_pkg::fdp_phase_e phase;
        logic [2:0]          cmd;
        logic [15:0]         data;
        logic [15:0]         addr;
        logic                start;
        logic [15:0]         rdata;
    } fdp_main_s;

    fdp_main_s st;
    fdp_main_s next_st;

    fdp_if link ();

    logic       ctrl_wr;
    logic       data_wr;
    logic       src_ok;
    logic [7:0] ctrl_rd;
    logic       idle_ok;

    assign src_ok  = FROM_ROM || FROM_DATA_MEM;
    // A start still in flight counts as busy
    assign idle_ok = link.busy_n && !st.start;
    assign ctrl_wr = WR && (ADDR == fdp_pkg::FLASH_CTRL_OFF);
    assign data_wr = WR && (ADDR == fdp_pkg::FLASH_DATA_OFF) && src_ok;

    always_comb begin
        ctrl_rd                                     = fdp_pkg::RD_PAD;
        ctrl_rd[fdp_pkg::CMD_MSB:fdp_pkg::CMD_LSB]  = st.cmd;
        ctrl_rd[fdp_pkg::BUSY_BIT-1:fdp_pkg::CMD_MSB+1] = fdp_pkg::CTRL_RSVD;
        ctrl_rd[fdp_pkg::BUSY_BIT]                  = link.busy_n;
    end

    always_comb begin
        next_st       = st;
        next_st.start = 1'b0;
        next_st.rdata = {fdp_pkg::RD_PAD, fdp_pkg::RD_PAD};

        // Stored value always tracks accepted writes
        if (data_wr) begin
            next_st.data = WDATA;
        end

        if (ctrl_wr && idle_ok) begin
            next_st.cmd = WDATA[fdp_pkg::CMD_MSB:fdp_pkg::CMD_LSB];
            case (WDATA[fdp_pkg::CMD_MSB:fdp_pkg::CMD_LSB])
                fdp_pkg::CMD_WR_INFO,
                fdp_pkg::CMD_WR_MAIN,
                fdp_pkg::CMD_ER_PAGE: begin
                    next_st.phase = fdp_pkg::FDP_ADDR;
                end
                fdp_pkg::CMD_ER_INFO,
                fdp_pkg::CMD_ER_MASS: begin
                    // No address or data needed
                    next_st.phase = fdp_pkg::FDP_IDLE;
                    next_st.start = 1'b1;
                end
                default: begin
                    next_st.phase = fdp_pkg::FDP_IDLE;
                end
            endcase
        end else if (data_wr && idle_ok) begin
            case (st.phase)
                fdp_pkg::FDP_ADDR: begin
                    next_st.addr = WDATA;
                    if (st.cmd == fdp_pkg::CMD_ER_PAGE) begin
                        next_st.phase = fdp_pkg::FDP_IDLE;
                        next_st.start = 1'b1;
                    end else begin
                        next_st.phase = fdp_pkg::FDP_DATA;
                    end
                end
                fdp_pkg::FDP_DATA: begin
                    next_st.phase = fdp_pkg::FDP_IDLE;
                    next_st.start = 1'b1;
                end
                default: begin
                    // Without a loaded command the array is untouched
                    next_st.phase = fdp_pkg::FDP_IDLE;
                end
            endcase
        end

        if (RD) begin
            case (ADDR)
                fdp_pkg::FLASH_DATA_OFF: begin
                    next_st.rdata = st.data;
                end
                fdp_pkg::FLASH_CTRL_OFF: begin
                    next_st.rdata = {fdp_pkg::RD_PAD, ctrl_rd};
                end
                default: begin
                    next_st.rdata = {fdp_pkg::RD_PAD, fdp_pkg::RD_PAD};
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st       <= '0;
            st.data  <= fdp_pkg::FLASH_DATA_RST;
            st.cmd   <= fdp_pkg::FLASH_CMD_RST;
            st.phase <= fdp_pkg::FDP_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign link.start   = st.start;
    assign link.cmd     = st.cmd;
    assign link.addr    = st.addr;
    assign link.data    = st.data;
    assign RDATA        = st.rdata;
    assign FLASH_BUSY_N = link.busy_n;

    fdp_seq u_seq (
        .clock       (CLOCK),
        .rst         (RST),
        .link        (link.seq),
        .array_go    (ARRAY_GO),
        .array_op    (ARRAY_OP),
        .array_addr  (ARRAY_ADDR),
        .array_wdata (ARRAY_WDATA),
        .array_done  (ARRAY_DONE)
    );

    a_data_reset_zero: assert property (@(posedge CLOCK) disable iff (RST)
        $past(RST) |-> st.data == fdp_pkg::FLASH_DATA_RST && st.phase == fdp_pkg::FDP_IDLE)
        else $error("data register not zero after reset");

    a_write_src_gate: assert property (@(posedge CLOCK) disable iff (RST)
        WR && (ADDR == fdp_pkg::FLASH_DATA_OFF) && !FROM_ROM && !FROM_DATA_MEM
        |=> st.data == $past(st.data))
        else $error("data register took a write from a barred source");

    a_ctrl_busy_lock: assert property (@(posedge CLOCK) disable iff (RST)
        ctrl_wr && !link.busy_n |=> st.cmd == $past(st.cmd) && !st.start)
        else $error("control write altered command while busy");

    a_no_cmd_inert: assert property (@(posedge CLOCK) disable iff (RST)
        data_wr && !ctrl_wr && st.phase == fdp_pkg::FDP_IDLE |=> !st.start ##1 !ARRAY_GO)
        else $error("data write started array without a command");

    a_prog_path: assert property (@(posedge CLOCK) disable iff (RST)
        data_wr && link.busy_n && st.phase == fdp_pkg::FDP_DATA
        |=> st.start ##1 ARRAY_GO && ARRAY_WDATA == $past(WDATA, 2) && !FLASH_BUSY_N)
        else $error("program data not passed to flash array");

    a_reserved_noop: assert property (@(posedge CLOCK) disable iff (RST)
        ctrl_wr && link.busy_n && (WDATA[2:0] == 3'h0 || WDATA[2:0] == 3'h1
        || WDATA[2:0] == 3'h7) |=> (!st.start && st.phase == fdp_pkg::FDP_IDLE)[*2])
        else $error("reserved command code produced activity");

    a_data_readback: assert property (@(posedge CLOCK) disable iff (RST)
        RD && (ADDR == fdp_pkg::FLASH_DATA_OFF) |=> RDATA == $past(st.data))
        else $error("data read did not return stored value");

    a_busy_on_seq: assert property (@(posedge CLOCK) disable iff (RST)
        st.start |=> !FLASH_BUSY_N)
        else $error("busy flag not low after command sequence");

    a_ctrl_pend_lock: assert property (@(posedge CLOCK) disable iff (RST)
        ctrl_wr && st.start |=> st.cmd == $past(st.cmd) && !st.start)
        else $error("control write altered command before busy fell");

    a_erase_start: assert property (@(posedge CLOCK) disable iff (RST)
        ctrl_wr && idle_ok && (WDATA[2:0] == fdp_pkg::CMD_ER_INFO
        || WDATA[2:0] == fdp_pkg::CMD_ER_MASS)
        |=> st.start ##1 ARRAY_GO && ARRAY_OP == $past(WDATA[2:0], 2) && !FLASH_BUSY_N)
        else $error("erase command did not start flash array");

    a_page_erase_addr: assert property (@(posedge CLOCK) disable iff (RST)
        data_wr && idle_ok && st.phase == fdp_pkg::FDP_ADDR && st.cmd == fdp_pkg::CMD_ER_PAGE
        |=> st.start ##1 ARRAY_GO && ARRAY_ADDR == $past(WDATA, 2))
        else $error("page erase address not passed to flash array");

    a_data_store: assert property (@(posedge CLOCK) disable iff (RST)
        data_wr |=> st.data == $past(WDATA))
        else $error("accepted data write not stored");

    a_rdata_idle_zero: assert property (@(posedge CLOCK) disable iff (RST)
        !RD |=> RDATA == {fdp_pkg::RD_PAD, fdp_pkg::RD_PAD})
        else $error("read data not zero outside read cycle");

    a_busy_read_bit: assert property (@(posedge CLOCK) disable iff (RST)
        RD && (ADDR == fdp_pkg::FLASH_CTRL_OFF)
        |=> RDATA[fdp_pkg::BUSY_BIT] == $past(FLASH_BUSY_N))
        else $error("control read busy bit wrong");

endmodule : fdp_flash_data_port

`default_nettype wire

// ### verif/fdp_array_model.sv
`timescale 1ns/10ps
`default_nettype none

module fdp_array_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Sequencer side
    input  wire logic       go,
    input  wire logic [7:0] delay,
    output logic            done
);
    logic [7:0] left;
    logic       run;

    // One-cycle finish pulse a chosen number of cycles after each start
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run  <= 1'b0;
            left <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= run && left == 8'h00;
            if (go) begin
                run  <= 1'b1;
                left <= delay;
            end else if (run && left == 8'h00) begin
                run <= 1'b0;
            end else if (run) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule : fdp_array_model

`default_nettype wire

// ### verif/fdp_flash_data_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

module fdp_flash_data_port_tb;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  ADDR = 8'h00;
    logic [15:0] WDATA = 16'h0000;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic        FROM_ROM = 1'b0;
    logic        FROM_DATA_MEM = 1'b0;
    logic [7:0]  DELAY = 8'h01;
    logic [15:0] RDATA, ARRAY_ADDR, ARRAY_WDATA, a, d;
    logic [2:0]  ARRAY_OP;
    logic        ARRAY_GO, ARRAY_DONE, FLASH_BUSY_N;
    logic        rd_pend = 1'b0;
    logic [69:0] go_q[$];
    logic [15:0] rd_q[$];
    logic [69:0] g;
    logic [34:0] m, seen_go;
    int          num_errors = 0, samples_checked = 0, cycles = 0, n;

    always #25 CLOCK = ~CLOCK;

    fdp_flash_data_port fdp_flash_data_port_i (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FROM_ROM(FROM_ROM),
        .FROM_DATA_MEM(FROM_DATA_MEM), .ARRAY_GO(ARRAY_GO), .ARRAY_OP(ARRAY_OP),
        .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_WDATA(ARRAY_WDATA), .ARRAY_DONE(ARRAY_DONE),
        .FLASH_BUSY_N(FLASH_BUSY_N));

    fdp_array_model fdp_array_model_i (.clock(CLOCK), .rst(RST), .go(ARRAY_GO),
        .delay(DELAY), .done(ARRAY_DONE));

    task automatic chk(input string what, input logic [34:0] seen, input logic [34:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [15:0] v);
        ADDR  <= ad;
        WDATA <= v;
        WR    <= 1'b1;
        RD    <= 1'b0;
        @(posedge CLOCK);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [15:0] e);
        ADDR <= ad;
        RD   <= 1'b1;
        WR   <= 1'b0;
        rd_q.push_back(e);
        @(posedge CLOCK);
    endtask : rd

    task automatic idle(input int k);
        WR <= 1'b0;
        RD <= 1'b0;
        repeat (k) @(posedge CLOCK);
    endtask : idle

    task automatic do_reset;
        RST <= 1'b1;
        idle(6);
        RST <= 1'b0;
        @(posedge CLOCK);
    endtask : do_reset

    task automatic wait_idle;
        n = 0;
        while (FLASH_BUSY_N !== 1'b1 && n < 200) begin
            @(posedge CLOCK);
            n++;
        end
        chk("busy release", {34'h0, FLASH_BUSY_N}, 35'h1);
    endtask : wait_idle

    task automatic tally_and_finish;
        chk("pending starts", 35'(go_q.size()), 35'h0);
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Results are settled by the falling edge
    always @(negedge CLOCK) begin
        if (rd_pend) begin
            chk("read data", {19'h0, RDATA}, {19'h0, rd_q.pop_front()});
        end
        rd_pend = RD;
        if (ARRAY_GO === 1'b1) begin
            chk("busy at start", {34'h0, FLASH_BUSY_N}, 35'h0);
            if (go_q.size() == 0) begin
                chk("stray start", 35'h1, 35'h0);
            end else begin
                g = go_q.pop_front();
                seen_go = {ARRAY_OP, ARRAY_ADDR, ARRAY_WDATA} & g[69:35];
                chk("array start", seen_go, g[34:0]);
            end
        end
    end

    always @(posedge CLOCK) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        n = $urandom(32'h0082422E);
        do_reset();
        rd(8'h0F, 16'h0000);
        rd(8'h0E, 16'h0080);
        a = 16'($urandom());
        wr(8'h0F, a);
        rd(8'h0F, 16'h0000);
        FROM_DATA_MEM <= 1'b1;
        wr(8'h0F, a);
        rd(8'h0F, a);
        rd(8'h0E, 16'h0080);
        // Let the last read be checked before reset clears it
        idle(1);
        do_reset();
        rd(8'h0F, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            a = 16'($urandom());
            d = 16'($urandom());
            {FROM_ROM, FROM_DATA_MEM} <= 2'($urandom_range(1, 3));
            DELAY <= (c == 3) ? 8'h28 : 8'($urandom_range(0, 8));
            n = (c == 4 || c == 6) ? 0 : (c == 5) ? 1 : 2;
            m = (n == 2) ? {35{1'b1}} : (n == 1) ? {19'h7FFFF, 16'h0000} : {3'h7, 32'h0};
            if (c >= 2 && c <= 6) begin
                go_q.push_back({m, {3'(c), a, d} & m});
            end
            wr(8'h0E, 16'(c));
            if (n > 0) wr(8'h0F, a);
            if (n > 1) wr(8'h0F, d);
            idle(3);
            if (c == 3) begin
                rd(8'h0E, 16'h0003);
                wr(8'h0E, 16'h0005);
                rd(8'h0E, 16'h0003);
                rd(8'h0F, d);
                idle(1);
            end else if (c < 2 || c == 7) begin
                rd(8'h0E, 16'h0080 | 16'(c));
                idle(1);
            end
            wait_idle();
        end
        idle(2);
        tally_and_finish();
    end
endmodule : fdp_flash_data_port_tb

`default_nettype wire
